// >>> flash_pin_cfg.svh
// constants for the serial flash pin interface
`ifndef FLASH_PIN_CFG_SVH
`define FLASH_PIN_CFG_SVH

`define SR_W 8
`define SR_RST 8'h00
`define SR_PROT_MASK 8'hfc
`define SR_STATUS_WRITE_DISABLE_BIT_BIT 7
`define SR_QE_BIT 6
`define BYTE_W 8
`define BYTE_ZERO 8'h00
`define CNT_W 4
`define CNT_ZERO 4'h0
`define BYTE_BITS 4'h8
`define STEP_1 4'h1
`define STEP_2 4'h2
`define STEP_4 4'h4
`define LANES 4
`define LANES_ZERO 4'h0
`define OE_QUAD 4'hf
`define OE_DUAL 4'h3
`define OE_SINGLE 4'h2

`endif

// >>> flash_pin_pkg.sv
// types for the serial flash pin interface
package flash_pin_pkg;

    typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} lane_mode_t;

    typedef enum logic [1:0] {ROLE_PAUSE, ROLE_RESET, ROLE_DATA} pin3_role_t;

    typedef enum logic [2:0] {ST_UNARMED, ST_STANDBY, ST_ACTIVE, ST_PAUSED, ST_PIN_RESET} link_state_t;

endpackage

// >>> pin_role_decode.sv
// role decode of the write-protect and hold/reset pins
module pin_role_decode (
    input wire logic quad_enable_bit,
    input wire logic dedicated_reset_present,
    input wire logic dedicated_reset_disable,
    input wire logic hold_reset_select_bit,
    input wire logic lane2_in,
    input wire logic lane3_in,
    input wire logic rst_pin_n,
    output flash_pin_pkg::pin3_role_t pin3_role,
    output logic wp_low,
    output logic pause_req,
    output logic reset_req
);
    logic dedicated_on;

    // ****************************************************
    // pin roles
    // ****************************************************
    assign dedicated_on = dedicated_reset_present & ~dedicated_reset_disable;
    assign wp_low = ~quad_enable_bit & ~lane2_in;

    always_comb begin
        if (quad_enable_bit) begin
            pin3_role = flash_pin_pkg::ROLE_DATA;
        end else if (dedicated_on) begin
            pin3_role = flash_pin_pkg::ROLE_PAUSE;
        end else if (hold_reset_select_bit) begin
            pin3_role = flash_pin_pkg::ROLE_RESET;
        end else begin
            pin3_role = flash_pin_pkg::ROLE_PAUSE;
        end
    end

    assign pause_req = (pin3_role == flash_pin_pkg::ROLE_PAUSE) & ~lane3_in;
    assign reset_req = ((pin3_role == flash_pin_pkg::ROLE_RESET) & ~lane3_in)
                     | (dedicated_on & ~rst_pin_n);
endmodule // pin_role_decode

// >>> status_guard.sv
// status register with write-protect gating
`include "flash_pin_cfg.svh"
module status_guard (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wr_req,
    input wire logic [`SR_W-1:0] wr_data,
    input wire logic wp_low,
    output logic [`SR_W-1:0] status_r,
    output logic wr_blocked_r
);
    logic blocked;

    // ****************************************************
    // guarded write
    // ****************************************************
    assign blocked = status_r[`SR_STATUS_WRITE_DISABLE_BIT_BIT] & wp_low;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= `SR_RST;
        end else if (wr_req && blocked) begin
            status_r <= (status_r & `SR_PROT_MASK) | (wr_data & ~`SR_PROT_MASK);
        end else if (wr_req) begin
            status_r <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_blocked_r <= 1'b0;
        end else begin
            wr_blocked_r <= wr_req & blocked;
        end
    end
endmodule // status_guard

// >>> flash_pin_if.sv
// pin-level front end of a serial flash device
`include "flash_pin_cfg.svh"
module flash_pin_if (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic rst_pin_n,
    input wire logic data_lane_0_in,
    output logic data_lane_0_out,
    output logic data_lane_0_oe,
    input wire logic data_lane_1_in,
    output logic data_lane_1_out,
    output logic data_lane_1_oe,
    input wire logic data_lane_2_in,
    output logic data_lane_2_out,
    output logic data_lane_2_oe,
    input wire logic data_lane_3_in,
    output logic data_lane_3_out,
    output logic data_lane_3_oe,
    input wire flash_pin_pkg::lane_mode_t lane_mode,
    input wire logic dedicated_reset_present,
    input wire logic dedicated_reset_disable,
    input wire logic hold_reset_select_bit,
    input wire logic status_wr_req,
    input wire logic [`SR_W-1:0] status_wr_data,
    input wire logic tx_en,
    input wire logic tx_load,
    input wire logic [`BYTE_W-1:0] tx_byte,
    output logic [`SR_W-1:0] status_r,
    output logic status_wr_blocked_r,
    output logic [`BYTE_W-1:0] rx_byte_r,
    output logic rx_valid_r,
    output logic tx_empty_r,
    output logic frame_start_r,
    output logic standby_r,
    output logic paused_r,
    output logic in_reset_r
);
    flash_pin_pkg::link_state_t state_r;
    flash_pin_pkg::link_state_t state_nxt;
    flash_pin_pkg::pin3_role_t pin3_role;
    logic sck_prev_r;
    logic sck_seen_r;
    logic sck_rise;
    logic sck_fall;
    logic wp_low;
    logic pause_req;
    logic reset_req;
    logic quad_on;
    logic [`CNT_W-1:0] step;
    logic [`BYTE_W-1:0] rx_shift_r;
    logic [`BYTE_W-1:0] rx_shift_nxt;
    logic [`CNT_W-1:0] rx_cnt_r;
    logic [`CNT_W-1:0] rx_cnt_nxt;
    logic [`BYTE_W-1:0] tx_shift_r;
    logic [`CNT_W-1:0] tx_cnt_r;
    logic [`CNT_W-1:0] tx_cnt_nxt;
    logic [`LANES-1:0] lane_in;
    logic [`LANES-1:0] lane_out_r;
    logic [`LANES-1:0] lane_oe_r;
    logic [`LANES-1:0] lane_out_nxt;
    logic [`LANES-1:0] lane_oe_nxt;
    logic active;
    logic rx_take;
    logic tx_take;

    // ****************************************************
    // pin roles and status register
    // ****************************************************
    pin_role_decode u_roles (
        .quad_enable_bit(status_r[`SR_QE_BIT]),
        .dedicated_reset_present(dedicated_reset_present),
        .dedicated_reset_disable(dedicated_reset_disable),
        .hold_reset_select_bit(hold_reset_select_bit),
        .lane2_in(data_lane_2_in),
        .lane3_in(data_lane_3_in),
        .rst_pin_n(rst_pin_n),
        .pin3_role(pin3_role),
        .wp_low(wp_low),
        .pause_req(pause_req),
        .reset_req(reset_req)
    );

    status_guard u_status (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .wr_req(status_wr_req),
        .wr_data(status_wr_data),
        .wp_low(wp_low),
        .status_r(status_r),
        .wr_blocked_r(status_wr_blocked_r)
    );

    // ****************************************************
    // serial clock edges
    // ****************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck;
        end
    end

    // no edge on the first sample after reset, whatever the idle level
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_seen_r <= 1'b0;
        end else begin
            sck_seen_r <= 1'b1;
        end
    end

    assign sck_rise = sck & ~sck_prev_r & sck_seen_r;
    assign sck_fall = ~sck & sck_prev_r & sck_seen_r;
    assign lane_in = {data_lane_3_in, data_lane_2_in, data_lane_1_in, data_lane_0_in};

    // quad lanes only exist with quad enable set
    assign quad_on = (lane_mode == flash_pin_pkg::LANE_QUAD)
                   & (pin3_role == flash_pin_pkg::ROLE_DATA);

    always_comb begin
        if (quad_on) begin
            step = `STEP_4;
        end else if (lane_mode == flash_pin_pkg::LANE_DUAL) begin
            step = `STEP_2;
        end else begin
            step = `STEP_1;
        end
    end

    // ****************************************************
    // link state
    // ****************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            flash_pin_pkg::ST_UNARMED: begin
                if (cs_n) begin
                    state_nxt = flash_pin_pkg::ST_STANDBY;
                end
            end
            flash_pin_pkg::ST_STANDBY: begin
                if (!cs_n) begin
                    state_nxt = flash_pin_pkg::ST_ACTIVE;
                end
            end
            flash_pin_pkg::ST_ACTIVE: begin
                if (cs_n) begin
                    state_nxt = flash_pin_pkg::ST_STANDBY;
                end else if (pause_req) begin
                    state_nxt = flash_pin_pkg::ST_PAUSED;
                end
            end
            flash_pin_pkg::ST_PAUSED: begin
                if (cs_n) begin
                    state_nxt = flash_pin_pkg::ST_STANDBY;
                end else if (!pause_req) begin
                    state_nxt = flash_pin_pkg::ST_ACTIVE;
                end
            end
            flash_pin_pkg::ST_PIN_RESET: begin
                state_nxt = flash_pin_pkg::ST_UNARMED;
            end
            default: begin
                state_nxt = flash_pin_pkg::ST_UNARMED;
            end
        endcase
        if (reset_req) begin
            state_nxt = flash_pin_pkg::ST_PIN_RESET;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= flash_pin_pkg::ST_UNARMED;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign active = (state_r == flash_pin_pkg::ST_ACTIVE) & ~cs_n & ~pause_req & ~reset_req;

    // ****************************************************
    // status outputs
    // ****************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            standby_r <= 1'b1;
            paused_r <= 1'b0;
            in_reset_r <= 1'b0;
            frame_start_r <= 1'b0;
        end else begin
            standby_r <= (state_nxt == flash_pin_pkg::ST_STANDBY)
                       | (state_nxt == flash_pin_pkg::ST_UNARMED);
            paused_r <= state_nxt == flash_pin_pkg::ST_PAUSED;
            in_reset_r <= state_nxt == flash_pin_pkg::ST_PIN_RESET;
            frame_start_r <= (state_r == flash_pin_pkg::ST_STANDBY)
                           & (state_nxt == flash_pin_pkg::ST_ACTIVE);
        end
    end

    // ****************************************************
    // receive path
    // ****************************************************
    assign rx_take = active & sck_rise;

    always_comb begin
        rx_shift_nxt = rx_shift_r;
        rx_cnt_nxt = rx_cnt_r;
        if (rx_take) begin
            rx_cnt_nxt = rx_cnt_r + step;
            if (quad_on) begin
                rx_shift_nxt = {rx_shift_r[`BYTE_W-5:0], lane_in};
            end else if (lane_mode == flash_pin_pkg::LANE_DUAL) begin
                rx_shift_nxt = {rx_shift_r[`BYTE_W-3:0], lane_in[1:0]};
            end else begin
                rx_shift_nxt = {rx_shift_r[`BYTE_W-2:0], lane_in[0]};
            end
        end
    end

    // partial sequence survives a pause, dropped only by deselect or reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_shift_r <= `BYTE_ZERO;
            rx_cnt_r <= `CNT_ZERO;
        end else if (cs_n || reset_req) begin
            rx_shift_r <= `BYTE_ZERO;
            rx_cnt_r <= `CNT_ZERO;
        end else if (rx_cnt_nxt >= `BYTE_BITS) begin
            rx_shift_r <= rx_shift_nxt;
            rx_cnt_r <= `CNT_ZERO;
        end else begin
            rx_shift_r <= rx_shift_nxt;
            rx_cnt_r <= rx_cnt_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_byte_r <= `BYTE_ZERO;
            rx_valid_r <= 1'b0;
        end else begin
            rx_valid_r <= rx_take & (rx_cnt_nxt >= `BYTE_BITS);
            if (rx_take && (rx_cnt_nxt >= `BYTE_BITS)) begin
                rx_byte_r <= rx_shift_nxt;
            end
        end
    end

    // ****************************************************
    // transmit path
    // ****************************************************
    assign tx_take = active & tx_en & sck_fall & ~tx_empty_r;
    assign tx_cnt_nxt = tx_cnt_r + step;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_shift_r <= `BYTE_ZERO;
            tx_cnt_r <= `CNT_ZERO;
            tx_empty_r <= 1'b1;
        end else if (cs_n || reset_req) begin
            tx_cnt_r <= `CNT_ZERO;
            tx_empty_r <= 1'b1;
        end else if (tx_load && tx_empty_r) begin
            tx_shift_r <= tx_byte;
            tx_cnt_r <= `CNT_ZERO;
            tx_empty_r <= 1'b0;
        end else if (tx_take) begin
            tx_shift_r <= tx_shift_r << step;
            tx_cnt_r <= tx_cnt_nxt;
            tx_empty_r <= tx_cnt_nxt >= `BYTE_BITS;
        end
    end

    always_comb begin
        lane_out_nxt = lane_out_r;
        if (tx_take) begin
            if (quad_on) begin
                lane_out_nxt = tx_shift_r[`BYTE_W-1:`BYTE_W-4];
            end else if (lane_mode == flash_pin_pkg::LANE_DUAL) begin
                lane_out_nxt = {2'b00, tx_shift_r[`BYTE_W-1:`BYTE_W-2]};
            end else begin
                lane_out_nxt = {2'b00, tx_shift_r[`BYTE_W-1], 1'b0};
            end
        end
    end

    // drivers off outside an active, unpaused, unreset selection
    always_comb begin
        lane_oe_nxt = `LANES_ZERO;
        if (active && tx_en) begin
            if (quad_on) begin
                lane_oe_nxt = `OE_QUAD;
            end else if (lane_mode == flash_pin_pkg::LANE_DUAL) begin
                lane_oe_nxt = `OE_DUAL;
            end else begin
                lane_oe_nxt = `OE_SINGLE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lane_out_r <= `LANES_ZERO;
            lane_oe_r <= `LANES_ZERO;
        end else begin
            lane_out_r <= lane_out_nxt;
            lane_oe_r <= lane_oe_nxt;
        end
    end

    assign data_lane_0_out = lane_out_r[0];
    assign data_lane_1_out = lane_out_r[1];
    assign data_lane_2_out = lane_out_r[2];
    assign data_lane_3_out = lane_out_r[3];
    assign data_lane_0_oe = lane_oe_r[0];
    assign data_lane_1_oe = lane_oe_r[1];
    assign data_lane_2_oe = lane_oe_r[2];
    assign data_lane_3_oe = lane_oe_r[3];
endmodule // flash_pin_if

// >>> flash_pin_if_chk.sv
// port assertions for the flash pin front end
module flash_pin_if_chk (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic data_lane_0_oe,
    input wire logic data_lane_1_oe,
    input wire logic data_lane_2_oe,
    input wire logic data_lane_3_oe,
    input wire logic data_lane_2_in,
    input wire logic status_wr_req,
    input wire logic [7:0] status_wr_data,
    input wire logic [7:0] status_r,
    input wire logic status_wr_blocked_r,
    input wire logic rx_valid_r,
    input wire logic frame_start_r,
    input wire logic standby_r,
    input wire logic paused_r,
    input wire logic in_reset_r
);
    timeunit 1ns;
    timeprecision 1ns;
    logic oe_any;
    logic wp_block;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    assign oe_any = data_lane_0_oe | data_lane_1_oe | data_lane_2_oe | data_lane_3_oe;
    assign wp_block = status_r[7] & ~status_r[6] & ~data_lane_2_in;
    // ****
    // pin checks
    // ****
    a_desel_quiet: assert property (cs_n [*4] |-> !oe_any && standby_r)
        else $error("awake while deselected");
    a_select_wakes: assert property (frame_start_r |-> !$past(cs_n) ##1 !standby_r)
        else $error("bad frame start");
    a_rx_selected: assert property (rx_valid_r |-> !$past(cs_n) && !$past(in_reset_r))
        else $error("byte taken while deselected");
    a_rx_one_pulse: assert property (rx_valid_r |=> !rx_valid_r)
        else $error("receive pulse too long");
    a_pause_quiet: assert property (paused_r && $past(paused_r) |-> !data_lane_1_oe && !rx_valid_r)
        else $error("activity while paused");
    a_reset_quiet: assert property (in_reset_r && $past(in_reset_r) |-> !oe_any)
        else $error("driving in reset");
    a_status_blocked: assert property (status_wr_req && wp_block |=> status_wr_blocked_r
        && status_r[7:2] == $past(status_r[7:2])) else $error("protected bits written");
    a_status_open: assert property (status_wr_req && !wp_block |=> !status_wr_blocked_r
        && status_r == $past(status_wr_data)) else $error("status write lost");
endmodule // flash_pin_if_chk

bind flash_pin_if flash_pin_if_chk u_chk (
    .core_clk, .arst_n, .cs_n, .data_lane_0_oe, .data_lane_1_oe, .data_lane_2_oe,
    .data_lane_3_oe, .data_lane_2_in, .status_wr_req, .status_wr_data, .status_r,
    .status_wr_blocked_r, .rx_valid_r, .frame_start_r, .standby_r, .paused_r, .in_reset_r
);

// >>> host.sv
// host controller model driving the flash pins
module host (
    input wire logic core_clk,
    output logic cs_n,
    output logic sck,
    output logic [3:0] lanes,
    input wire logic [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wp_n = 1'b1;
    logic hold_n = 1'b1;
    // ****
    // pin tasks
    // ****
    initial begin
        cs_n = 1'b0;
        sck = 1'b1;
        lanes = 4'hc;
    end
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #2;
        end
    endtask
    task automatic set_pins(input logic wp, input logic hold);
        wp_n = wp;
        hold_n = hold;
        lanes = {hold, wp, lanes[1:0]};
    endtask
    task automatic select();
        cs_n = 1'b1;
        tick(3);
        cs_n = 1'b0;
        tick(3);
    endtask
    task automatic deselect();
        cs_n = 1'b1;
        tick(4);
    endtask
    // w lanes a step, msb group first; rd drives the inverse of the previous lane values instead of din
    task automatic xfer(input int w, input int n, input bit rd,
                        input logic [7:0] din, output logic [7:0] dout);
        logic [3:0] dm;
        logic [3:0] t;
        logic [3:0] p;
        dout = 8'h00;
        dm = rd ? 4'h0 : 4'hf >> (4 - w);
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            t = (4'(din >> (8 - w * (i + 1))) & dm) | (~lanes & ~dm);
            lanes = (w < 4) ? {hold_n, wp_n, t[1:0]} : t;
            tick(3);
            p = (w == 1) ? {3'h0, pins[1]} : pins & (4'hf >> (4 - w));
            dout = (dout << w) | {4'h0, p};
            sck = 1'b1;
            tick(2);
        end
    endtask
endmodule // host

// >>> flash_pin_if_tb.sv
// self-checking bench for the flash pin front end
module flash_pin_if_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk;
    logic arst_n;
    logic rst_pin_n;
    logic dedicated_reset_present;
    logic dedicated_reset_disable;
    logic hold_reset_select_bit;
    logic status_wr_req;
    logic [7:0] status_wr_data;
    logic tx_en;
    logic tx_load;
    logic [7:0] tx_byte;
    flash_pin_pkg::lane_mode_t lane_mode;
    logic [3:0] l_out, l_oe, hl, pins;
    logic [7:0] status_r, rx_byte_r, b, got;
    logic [7:0] sr = 8'h00;
    logic cs_n, sck, status_wr_blocked_r, rx_valid_r, tx_empty_r;
    logic frame_start_r, standby_r, paused_r, in_reset_r, wp, q, r;
    int failures = 0;
    int checked = 0;
    int rx_cnt = 0;
    int cyc = 0;
    integer seed = 14868;
    logic [8:0] corners [4] = '{9'h080, 9'h03f, 9'h1c0, 9'h041};
    logic [6:0] roles [8] = '{7'h02, 7'h09, 7'h2a, 7'h39, 7'h32, 7'h25, 7'h34, 7'h48};
    flash_pin_if u_flash_pin_if (
        .core_clk, .arst_n, .cs_n, .sck, .rst_pin_n,
        .data_lane_0_in(pins[0]), .data_lane_0_out(l_out[0]), .data_lane_0_oe(l_oe[0]),
        .data_lane_1_in(pins[1]), .data_lane_1_out(l_out[1]), .data_lane_1_oe(l_oe[1]),
        .data_lane_2_in(pins[2]), .data_lane_2_out(l_out[2]), .data_lane_2_oe(l_oe[2]),
        .data_lane_3_in(pins[3]), .data_lane_3_out(l_out[3]), .data_lane_3_oe(l_oe[3]),
        .lane_mode, .dedicated_reset_present, .dedicated_reset_disable,
        .hold_reset_select_bit, .status_wr_req, .status_wr_data, .tx_en, .tx_load,
        .tx_byte, .status_r, .status_wr_blocked_r, .rx_byte_r, .rx_valid_r, .tx_empty_r,
        .frame_start_r, .standby_r, .paused_r, .in_reset_r
    );
    host u_host (.core_clk, .cs_n, .sck, .lanes(hl), .pins);
    assign pins = (l_oe & l_out) | (~l_oe & hl);
    always #25 core_clk = ~core_clk;
    // ****
    // checking
    // ****
    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr_status(input logic [7:0] d);
        logic blk;
        blk = sr[7] && !sr[6] && !u_host.wp_n;
        sr = blk ? {sr[7:2], d[1:0]} : d;
        status_wr_data = d;
        status_wr_req = 1'b1;
        u_host.tick(1);
        status_wr_req = 1'b0;
        check({7'h0, status_wr_blocked_r}, {7'h0, blk});
        check(status_r, sr);
        u_host.tick(1);
    endtask
    always @(negedge core_clk) begin
        cyc++;
        if (rx_valid_r === 1'b1) rx_cnt++;
        if (cyc == 5000) begin
            failures++;
            end_of_test();
        end
    end
    // ****
    // sequence
    // ****
    initial begin
        int w;
        int n0;
        core_clk = 1'b0;
        arst_n = 1'b0;
        rst_pin_n = 1'b1;
        dedicated_reset_present = 1'b1;
        dedicated_reset_disable = 1'b0;
        hold_reset_select_bit = 1'b0;
        status_wr_req = 1'b0;
        status_wr_data = 8'h00;
        tx_en = 1'b0;
        tx_load = 1'b0;
        tx_byte = 8'h00;
        lane_mode = flash_pin_pkg::LANE_SINGLE;
        repeat (6) @(posedge core_clk);
        #2;
        arst_n = 1'b1;
        u_host.tick(1);
        check({status_r[3:0], standby_r, tx_empty_r, paused_r, in_reset_r}, 8'h0c);
        u_host.xfer(1, 8, 1'b0, 8'ha5, got);
        check(8'(rx_cnt), 8'h00);
        u_host.deselect();
        u_host.xfer(1, 8, 1'b0, 8'h5a, got);
        check({3'h0, standby_r, l_oe}, {3'h0, 1'b1, 4'h0});
        check(8'(rx_cnt), 8'h00);
        $display("power-up test done");
        for (int m = 0; m < 3; m++) begin
            w = 1 << m;
            lane_mode = flash_pin_pkg::lane_mode_t'(m);
            wr_status(m == 2 ? 8'h40 : 8'h00);
            u_host.select();
            b = 8'($random(seed));
            n0 = rx_cnt;
            u_host.xfer(w, 8 / w, 1'b0, b, got);
            u_host.tick(1);
            check(rx_byte_r, b);
            check(8'(rx_cnt - n0), 8'h01);
            tx_byte = 8'($random(seed));
            tx_load = 1'b1;
            tx_en = 1'b1;
            u_host.tick(1);
            tx_load = 1'b0;
            u_host.tick(1);
            u_host.xfer(w, 8 / w, 1'b1, 8'h00, got);
            u_host.tick(2);
            check({got[7:1], tx_empty_r}, {tx_byte[7:1], 1'b1});
            check({7'h0, got[0]}, {7'h0, tx_byte[0]});
            tx_en = 1'b0;
            u_host.deselect();
            check({4'h0, l_oe}, 8'h00);
        end
        $display("lane test done");
        lane_mode = flash_pin_pkg::LANE_SINGLE;
        wr_status(8'h00);
        for (int i = 0; i < 20; i++) begin
            {wp, b} = (i < 4) ? corners[i] : 9'($random(seed));
            u_host.set_pins(wp, 1'b1);
            wr_status(b);
        end
        u_host.set_pins(1'b1, 1'b1);
        wr_status(8'h00);
        $display("status test done");
        u_host.select();
        b = 8'($random(seed));
        n0 = rx_cnt;
        tx_en = 1'b1;
        u_host.xfer(1, 4, 1'b0, b, got);
        u_host.set_pins(1'b1, 1'b0);
        u_host.tick(3);
        check({3'h0, paused_r, l_oe}, 8'h10);
        u_host.xfer(1, 8, 1'b0, ~b, got);
        check(8'(rx_cnt - n0), 8'h00);
        u_host.set_pins(1'b1, 1'b1);
        u_host.tick(3);
        u_host.xfer(1, 4, 1'b0, 8'(b << 4), got);
        u_host.tick(1);
        check(rx_byte_r, b);
        check(8'(rx_cnt - n0), 8'h01);
        tx_en = 1'b0;
        u_host.deselect();
        $display("pause test done");
        foreach (roles[i]) begin
            {q, dedicated_reset_present, dedicated_reset_disable, hold_reset_select_bit, r} =
                roles[i][6:2];
            wr_status({1'b0, q, 6'h00});
            u_host.select();
            if (r) rst_pin_n = 1'b0;
            else u_host.set_pins(1'b1, 1'b0);
            u_host.tick(3);
            check({6'h0, paused_r, in_reset_r}, {6'h0, roles[i][1:0]});
            rst_pin_n = 1'b1;
            u_host.set_pins(1'b1, 1'b1);
            u_host.tick(3);
            u_host.deselect();
        end
        $display("pin role test done");
        end_of_test();
    end
endmodule // flash_pin_if_tb
